// ==== logic/rspm_pin_cell.sv ====
// One dual-use pin: strap input while held, latched level, inverted LED drive.
// Assumes hold_in and sample_en come from the reset sequencer of the top.
`timescale 1ns/1ps
module rspm_pin_cell (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control
   input  wire logic hold_in,
   input  wire logic sample_en,
   input  wire logic status_in,
   // Pin
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   output logic      latch_ff
);
   logic pin_o_ff;
   logic pin_oe_ff;

   // Level is kept until the next power-on or hardware reset exit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_ff <= 1'b0;
      end else if (sample_en) begin
         latch_ff <= pin_i;
      end
   end

   // Asserted level is the complement of the strap; deasserted equals the strap,
   // so the pull resistor and LED see no current while idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_o_ff  <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else begin
         pin_o_ff  <= latch_ff ^ status_in;
         pin_oe_ff <= !hold_in;
      end
   end

   assign pin_o  = pin_o_ff;
   assign pin_oe = pin_oe_ff;

   a_cell_input_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      hold_in |=> !pin_oe_ff) else $error("pin driven while held as input");
endmodule : rspm_pin_cell

// ==== logic/rspm_pin_mux.sv ====
// Top of the strap / LED pin block with its AXI4-Lite register slave.
// Assumes hw_rst_n and all pin inputs are synchronous to aclk.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Pins input in reset, latch, then LEDs
// - Software reset keeps latches, pins stay outputs
// - Asserted output is inverse of latched level
// - Activity pin latch sets address bit 0
// - Activity pin shows valid link, inverted polarity
// - Mode latch plus speed selects interface
// - Collision pin shows collisions, inverted polarity
// - Latched configuration applies in hardware or software mode
module rspm_pin_mux
   import rspm_pkg::*;
(
   // Clock and power-on reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // Device reset pin and management mode
   input  wire logic               hw_rst_n,
   input  wire logic               hw_mode,
   // Status sources
   input  wire logic               link_valid,
   input  wire logic               collision_detect,
   // Dual-use pins
   input  wire logic               addr0_activity_pin_i,
   output logic                    addr0_activity_pin_o,
   output logic                    addr0_activity_pin_oe,
   input  wire logic               iface_mode_collision_pin_i,
   output logic                    iface_mode_collision_pin_o,
   output logic                    iface_mode_collision_pin_oe,
   input  wire logic               speed_select_pin,
   // Configuration results
   output logic                    mgmt_addr0,
   output rspm_iface_type          iface_sel,
   output logic                    sw_reset,
   // AXI4-Lite write
   input  wire logic [RSPM_AW-1:0] s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read
   input  wire logic [RSPM_AW-1:0] s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready
);
   rspm_phase_type     phase_ff;
   rspm_phase_type     nxt_phase;
   rspm_iface_type     iface_sel_ff;
   logic               mgmt_addr0_ff;
   logic               sw_reset_ff;
   logic [7:0]         sw_cnt_ff;
   logic               led_test_ff;
   logic               addr0_latch;
   logic               mode_latch;
   logic               speed_ff;
   logic               pin_hold;
   logic               sample_en;
   logic               awready_ff;
   logic               wready_ff;
   logic               aw_held_ff;
   logic               w_held_ff;
   logic [RSPM_AW-1:0] awaddr_ff;
   logic [31:0]        wdata_ff;
   logic [3:0]         wstrb_ff;
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               arready_ff;
   logic               rvalid_ff;
   logic [31:0]        rdata_ff;
   logic [1:0]         rresp_ff;
   logic               wr_exec;
   logic               ctrl_wr;
   logic [31:0]        rd_mux;
   logic               rd_hit;

   //////////////////////////////////////////////////////////////////////////
   // Reset sequencer: only power-on or the reset pin returns to input mode
   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         RSPM_PH_RESET:  nxt_phase = RSPM_PH_SAMPLE;
         RSPM_PH_SAMPLE: nxt_phase = RSPM_PH_RUN;
         RSPM_PH_RUN:    nxt_phase = RSPM_PH_RUN;
         default:        nxt_phase = RSPM_PH_RESET;
      endcase
      if (!hw_rst_n) begin
         nxt_phase = RSPM_PH_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_ff <= RSPM_PH_RESET;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // The strap is taken one cycle after release so the pull has settled
   assign sample_en = (phase_ff == RSPM_PH_SAMPLE) && hw_rst_n;
   // Software reset is not a term here, so the pins keep driving through it
   assign pin_hold  = !hw_rst_n || (phase_ff != RSPM_PH_RUN);

   //////////////////////////////////////////////////////////////////////////
   // Pins
   rspm_pin_cell u_addr0_cell (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .hold_in   (pin_hold),
      .sample_en (sample_en),
      .status_in (link_valid | led_test_ff),
      .pin_i     (addr0_activity_pin_i),
      .pin_o     (addr0_activity_pin_o),
      .pin_oe    (addr0_activity_pin_oe),
      .latch_ff  (addr0_latch)
   );

   rspm_pin_cell u_mode_cell (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .hold_in   (pin_hold),
      .sample_en (sample_en),
      .status_in (collision_detect | led_test_ff),
      .pin_i     (iface_mode_collision_pin_i),
      .pin_o     (iface_mode_collision_pin_o),
      .pin_oe    (iface_mode_collision_pin_oe),
      .latch_ff  (mode_latch)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_ff <= 1'b0;
      end else if (sample_en) begin
         speed_ff <= speed_select_pin;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Configuration outputs; hw_mode is only reported, never a term here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mgmt_addr0_ff <= 1'b0;
         iface_sel_ff  <= RSPM_IF_MII;
      end else begin
         mgmt_addr0_ff <= addr0_latch;
         if (!mode_latch) begin
            iface_sel_ff <= RSPM_IF_MII;
         end else if (speed_ff) begin
            iface_sel_ff <= RSPM_IF_SYM100;
         end else begin
            iface_sel_ff <= RSPM_IF_SER10;
         end
      end
   end

   assign mgmt_addr0 = mgmt_addr0_ff;
   assign iface_sel  = iface_sel_ff;
   assign sw_reset   = sw_reset_ff;

   //////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (s_axi_awvalid && awready_ff) begin
         aw_held_ff <= 1'b1;
         awready_ff <= 1'b0;
         awaddr_ff  <= s_axi_awaddr;
      end else if (bvalid_ff && s_axi_bready) begin
         aw_held_ff <= 1'b0;
         awready_ff <= 1'b1;
      end else if (!aw_held_ff && !bvalid_ff) begin
         awready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wready_ff <= 1'b0;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
      end else if (s_axi_wvalid && wready_ff) begin
         w_held_ff <= 1'b1;
         wready_ff <= 1'b0;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (bvalid_ff && s_axi_bready) begin
         w_held_ff <= 1'b0;
         wready_ff <= 1'b1;
      end else if (!w_held_ff && !bvalid_ff) begin
         wready_ff <= 1'b1;
      end
   end

   assign wr_exec = aw_held_ff && w_held_ff && !bvalid_ff;
   assign ctrl_wr = wr_exec && (awaddr_ff == RSPM_OFF_CTRL) && wstrb_ff[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RSPM_RESP_OKAY;
      end else if (wr_exec) begin
         bvalid_ff <= 1'b1;
         if ((awaddr_ff == RSPM_OFF_CTRL) || (awaddr_ff == RSPM_OFF_STATUS) ||
             (awaddr_ff == RSPM_OFF_LED)) begin
            bresp_ff <= RSPM_RESP_OKAY;
         end else begin
            bresp_ff <= RSPM_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Control: LED test and software reset pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         led_test_ff <= RSPM_LEDTEST_RST;
      end else if (ctrl_wr) begin
         led_test_ff <= wdata_ff[RSPM_CT_LEDTEST];
      end
   end

   // Touches no strap latch and no pin direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_reset_ff <= 1'b0;
         sw_cnt_ff   <= '0;
      end else if (ctrl_wr && wdata_ff[RSPM_CT_SWRST]) begin
         sw_reset_ff <= 1'b1;
         sw_cnt_ff   <= RSPM_SWRST_CNT;
      end else if (sw_cnt_ff > 8'h01) begin
         sw_cnt_ff <= sw_cnt_ff - 8'h01;
      end else begin
         sw_reset_ff <= 1'b0;
         sw_cnt_ff   <= '0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read
   always_comb begin
      rd_mux = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         RSPM_OFF_STATUS: begin
            rd_mux[RSPM_ST_ADDR0]                 = addr0_latch;
            rd_mux[RSPM_ST_MODE]                  = mode_latch;
            rd_mux[RSPM_ST_SPEED]                 = speed_ff;
            rd_mux[RSPM_ST_IFACE +: 3]            = iface_sel_ff;
            rd_mux[RSPM_ST_SWRST]                 = sw_reset_ff;
            rd_mux[RSPM_ST_HWMODE]                = hw_mode;
            rd_mux[RSPM_ST_RUN]                   = (phase_ff == RSPM_PH_RUN);
         end
         RSPM_OFF_CTRL: begin
            rd_mux[RSPM_CT_LEDTEST]               = led_test_ff;
         end
         RSPM_OFF_LED: begin
            rd_mux[3:0] = {iface_mode_collision_pin_oe, iface_mode_collision_pin_o,
                           addr0_activity_pin_oe, addr0_activity_pin_o};
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RSPM_RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_mux;
         rresp_ff   <= rd_hit ? RSPM_RESP_OKAY : RSPM_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_in_run;
      (phase_ff == RSPM_PH_RUN) && hw_rst_n;
   endsequence

   sequence s_reset_exit;
      !hw_rst_n ##1 hw_rst_n [*2];
   endsequence

   a_pins_input_reset: assert property (
      !hw_rst_n |=> !addr0_activity_pin_oe && !iface_mode_collision_pin_oe)
      else $error("pin driven during hardware reset");

   a_strap_at_exit: assert property (
      s_reset_exit |=> (addr0_latch == $past(addr0_activity_pin_i)) ##1
      addr0_activity_pin_oe) else $error("strap not latched at reset exit");

   a_swrst_keeps_cfg: assert property (
      (sw_reset_ff and s_in_run) |=> $stable(addr0_latch) && $stable(mode_latch)
      && $stable(speed_ff)) else $error("software reset changed strap");

   a_swrst_pins_out: assert property (
      (sw_reset_ff and s_in_run) ##1 s_in_run |-> addr0_activity_pin_oe &&
      iface_mode_collision_pin_oe) else $error("pins released in software reset");

   a_link_polarity: assert property (
      s_in_run |=> addr0_activity_pin_o ==
      ($past(addr0_latch) ^ $past(link_valid | led_test_ff)))
      else $error("link LED polarity wrong");

   a_col_polarity: assert property (
      s_in_run |=> iface_mode_collision_pin_o ==
      ($past(mode_latch) ^ $past(collision_detect | led_test_ff)))
      else $error("collision LED polarity wrong");

   a_addr0_map: assert property (
      s_in_run ##1 s_in_run |-> mgmt_addr0_ff == addr0_latch)
      else $error("address bit 0 differs from strap");

   a_iface_map: assert property (
      s_in_run ##1 s_in_run |-> iface_sel_ff == (!mode_latch ? RSPM_IF_MII :
      (speed_ff ? RSPM_IF_SYM100 : RSPM_IF_SER10)))
      else $error("interface select differs from strap");

   a_mode_ignored: assert property (
      s_in_run ##1 (s_in_run and $changed(hw_mode)) |=> $stable(iface_sel_ff) &&
      $stable(mgmt_addr0_ff)) else $error("management mode changed config");

   a_wr_resp_once: assert property (
      wr_exec |=> bvalid_ff ##1 !wr_exec) else $error("write answered twice");
endmodule : rspm_pin_mux

// ==== logic/rspm_pkg.sv ====
// Constants and types for the dual-use strap / LED pin block.
// Assumes a single 200 MHz clock and a 32-bit AXI4-Lite register port.
package rspm_pkg;
   localparam int          RSPM_AW          = 4;
   localparam logic [3:0]  RSPM_OFF_STATUS  = 4'h0;
   localparam logic [3:0]  RSPM_OFF_CTRL    = 4'h4;
   localparam logic [3:0]  RSPM_OFF_LED     = 4'h8;
   localparam logic [1:0]  RSPM_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RSPM_RESP_SLVERR = 2'h2;
   // Status register fields
   localparam int          RSPM_ST_ADDR0    = 0;
   localparam int          RSPM_ST_MODE     = 1;
   localparam int          RSPM_ST_SPEED    = 2;
   localparam int          RSPM_ST_IFACE    = 3;
   localparam int          RSPM_ST_SWRST    = 6;
   localparam int          RSPM_ST_HWMODE   = 7;
   localparam int          RSPM_ST_RUN      = 8;
   // Control register fields
   localparam int          RSPM_CT_SWRST    = 0;
   localparam int          RSPM_CT_LEDTEST  = 1;
   localparam logic        RSPM_LEDTEST_RST = 1'h0;
   // Software reset pulse length
   localparam int          RSPM_CLK_MHZ     = 200;
   localparam int          RSPM_SWRST_NS    = 100;
   localparam int          RSPM_SWRST_CYC   = (RSPM_SWRST_NS * RSPM_CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  RSPM_SWRST_CNT   = 8'(RSPM_SWRST_CYC);

   typedef enum logic [2:0] {
      RSPM_PH_RESET  = 3'h1,
      RSPM_PH_SAMPLE = 3'h2,
      RSPM_PH_RUN    = 3'h4
   } rspm_phase_type;

   typedef enum logic [2:0] {
      RSPM_IF_MII    = 3'h1,
      RSPM_IF_SER10  = 3'h2,
      RSPM_IF_SYM100 = 3'h4
   } rspm_iface_type;
endpackage : rspm_pkg

// ==== test/reset_strap_led_pin_mux_bench.sv ====
// Self-checking bench for the strap / LED pin block and its register port.
// Assumes the board model above stands on the pins; one 200 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module reset_strap_led_pin_mux_bench;
   import rspm_pkg::*;
   logic aclk, aresetn, hw_rst_n, hw_mode, link_valid, collision_detect;
   logic addr0_activity_pin_i, addr0_activity_pin_o, addr0_activity_pin_oe;
   logic iface_mode_collision_pin_i, iface_mode_collision_pin_o, iface_mode_collision_pin_oe;
   logic speed_select_pin, mgmt_addr0, sw_reset, act_strap, col_strap, act_lit, col_lit;
   rspm_iface_type iface_sel;
   logic [RSPM_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 18732;
   int sw_cnt = 0;
   rspm_pin_mux rspm_pin_mux_inst (.aclk, .aresetn, .hw_rst_n, .hw_mode, .link_valid,
      .collision_detect, .addr0_activity_pin_i, .addr0_activity_pin_o, .addr0_activity_pin_oe,
      .iface_mode_collision_pin_i, .iface_mode_collision_pin_o, .iface_mode_collision_pin_oe,
      .speed_select_pin, .mgmt_addr0, .iface_sel, .sw_reset, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   rspm_board_model rspm_board_model_inst (.act_strap, .col_strap,
      .act_o(addr0_activity_pin_o), .act_oe(addr0_activity_pin_oe),
      .col_o(iface_mode_collision_pin_o), .col_oe(iface_mode_collision_pin_oe),
      .act_i(addr0_activity_pin_i), .col_i(iface_mode_collision_pin_i), .act_lit, .col_lit);
   //////////////////////////////////////////////////////////////////////////////
   initial aclk = 1'h0;
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) if (sw_reset === 1'h1) sw_cnt <= sw_cnt + 1;
   // Pins must keep driving for the whole software reset
   always @(negedge aclk) if (sw_reset === 1'h1)
      `CHK({addr0_activity_pin_oe, iface_mode_collision_pin_oe}, 2'h3)
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] exp_iface(input logic m, input logic s);
      return !m ? 3'h1 : (s ? 3'h4 : 3'h2);
   endfunction : exp_iface
   function automatic logic [31:0] exp_status(input logic a, m, s, hm);
      return {23'h0, 1'h1, hm, 1'h0, exp_iface(m, s), s, m, a};
   endfunction : exp_status
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic tmo;
      num_errors++;
      give_verdict();
   endtask : tmo
   task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
      if (k == 50) tmo();
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            v = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
      if (k == 50) tmo();
   endtask : rd
   // Bounded wait until both pins drive, then let the latched results settle
   task automatic wait_run;
      int k;
      for (k = 0; k < 20; k++) begin
         @(negedge aclk);
         if (addr0_activity_pin_oe === 1'h1 && iface_mode_collision_pin_oe === 1'h1) break;
      end
      if (k == 20) tmo();
      repeat (2) @(negedge aclk);
   endtask : wait_run
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      int c;
      int k;
      aresetn <= 1'h0;
      hw_rst_n <= 1'h1;
      hw_mode <= 1'h0;
      link_valid <= 1'h0;
      collision_detect <= 1'h0;
      act_strap <= 1'h1;
      col_strap <= 1'h1;
      speed_select_pin <= 1'h0;
      s_axi_awaddr <= 4'h0;
      s_axi_awvalid <= 1'h0;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'h0;
      s_axi_bready <= 1'h0;
      s_axi_araddr <= 4'h0;
      s_axi_arvalid <= 1'h0;
      s_axi_rready <= 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      wait_run();
      `CHK(mgmt_addr0, 1'h1)
      `CHK(iface_sel, 3'h2)
      // Every strap combination through a hardware reset, management mode drawn at random each time
      for (c = 0; c < 8; c++) begin
         @(posedge aclk);
         hw_rst_n <= 1'h0;
         act_strap <= c[0];
         col_strap <= c[1];
         speed_select_pin <= c[2];
         hw_mode <= 1'($random(seed));
         repeat (3) @(negedge aclk);
         `CHK({addr0_activity_pin_oe, iface_mode_collision_pin_oe}, 2'h0)
         @(posedge aclk);
         hw_rst_n <= 1'h1;
         wait_run();
         `CHK(mgmt_addr0, c[0])
         `CHK(iface_sel, exp_iface(c[1], c[2]))
         for (k = 0; k < 4; k++) begin
            @(posedge aclk);
            link_valid <= 1'($random(seed));
            collision_detect <= 1'($random(seed));
            // Management mode flips while running; configuration must not follow
            hw_mode <= 1'($random(seed));
            repeat (2) @(negedge aclk);
            `CHK(act_lit, link_valid)
            `CHK(col_lit, collision_detect)
         end
         `CHK(mgmt_addr0, c[0])
         `CHK(iface_sel, exp_iface(c[1], c[2]))
         rd(RSPM_OFF_STATUS, d, r);
         `CHK(d, exp_status(c[0], c[1], c[2], hw_mode))
      end
      // Software reset with both LEDs on: a resample would read inverted straps
      @(posedge aclk);
      link_valid <= 1'h1;
      collision_detect <= 1'h1;
      sw_cnt = 0;
      wr(RSPM_OFF_CTRL, 32'h1, r);
      `CHK(r, RSPM_RESP_OKAY)
      repeat (40) @(negedge aclk);
      `CHK(sw_cnt, RSPM_SWRST_CYC)
      rd(RSPM_OFF_STATUS, d, r);
      `CHK(d, exp_status(1'h1, 1'h1, 1'h1, hw_mode))
      // LED test forces both LEDs lit with no link and no collision
      @(posedge aclk);
      link_valid <= 1'h0;
      collision_detect <= 1'h0;
      wr(RSPM_OFF_CTRL, 32'h2, r);
      repeat (2) @(negedge aclk);
      `CHK({act_lit, col_lit}, 2'h3)
      rd(RSPM_OFF_LED, d, r);
      `CHK(d, 32'h0000000a)
      rd(RSPM_OFF_CTRL, d, r);
      `CHK(d, 32'h00000002)
      wr(RSPM_OFF_CTRL, 32'h0, r);
      // Control write without byte lane 0 must leave the control bits alone
      s_axi_wstrb <= 4'he;
      wr(RSPM_OFF_CTRL, 32'h2, r);
      rd(RSPM_OFF_CTRL, d, r);
      `CHK(d, 32'h00000000)
      s_axi_wstrb <= 4'hf;
      wr(RSPM_OFF_STATUS, 32'hffffffff, r);
      `CHK(r, RSPM_RESP_OKAY)
      rd(RSPM_OFF_STATUS, d, r);
      `CHK(d, exp_status(1'h1, 1'h1, 1'h1, hw_mode))
      rd(4'hc, d, r);
      `CHK({r, d}, {RSPM_RESP_SLVERR, 32'h0})
      wr(4'hc, 32'h1, r);
      `CHK(r, RSPM_RESP_SLVERR)
      give_verdict();
   end
endmodule : reset_strap_led_pin_mux_bench

// ==== test/rspm_board_model.sv ====
// Board side of the two dual-use pins: a pull resistor with an LED in series.
// Assumes the bench sets each pull level before the reset that samples it.
`timescale 1ns/1ps
module rspm_board_model (
   // Pull levels
   input  wire logic act_strap,
   input  wire logic col_strap,
   // Device drive
   input  wire logic act_o,
   input  wire logic act_oe,
   input  wire logic col_o,
   input  wire logic col_oe,
   // Wire level and LED state
   output logic      act_i,
   output logic      col_i,
   output logic      act_lit,
   output logic      col_lit
);
   //////////////////////////////////////////////////////////////////////////////
   // A released pin settles at its pull level, never at the last driven value
   assign act_i   = act_oe ? act_o : act_strap;
   assign col_i   = col_oe ? col_o : col_strap;
   // LED sits on the pull path, so it lights only when driven against the pull
   assign act_lit = act_oe && (act_o != act_strap);
   assign col_lit = col_oe && (col_o != col_strap);
endmodule : rspm_board_model
